// [hw/hdxh_pkg.sv]
package hdxh_pkg;
    // host register addresses (octal)
    localparam logic [15:0] HDXH_CSR_ADDR   = 16'o177170;
    localparam logic [15:0] HDXH_DBR_ADDR   = 16'o177172;
    // control/status field positions
    localparam int          HDXH_BIT_GO     = 0;
    localparam int          HDXH_BIT_DONE   = 5;
    localparam int          HDXH_BIT_INTENB = 6;
    localparam int          HDXH_BIT_TREQ   = 7;
    localparam int          HDXH_BIT_INIT   = 14;
    localparam int          HDXH_BIT_ERR    = 15;
    // controller side: bit 7 enables transfer, bit 5 carries done
    localparam int          HDXH_ZBIT_XEN   = 7;
    localparam int          HDXH_ZBIT_DONE  = 5;
    // timing
    localparam int          HDXH_CLK_PS     = 4000;
    localparam int          HDXH_PULSE_NS   = 100;
    localparam int          HDXH_LOCK_NS    = 100;
    localparam int          HDXH_PULSE_CYC  = (HDXH_PULSE_NS * 1000) / HDXH_CLK_PS;
    localparam int          HDXH_LOCK_CYC   = (HDXH_LOCK_NS * 1000) / HDXH_CLK_PS;
    localparam logic [5:0]  HDXH_PULSE_LAST = 6'(HDXH_PULSE_CYC - 1);
    localparam logic [5:0]  HDXH_LOCK_LAST  = 6'(HDXH_LOCK_CYC - 1);
    // reset values
    localparam logic [7:0]  HDXH_DBR_RST    = 8'h00;
    localparam logic        HDXH_DONE_RST   = 1'b1;
    typedef enum logic [1:0] {HDXH_LK_OPEN, HDXH_LK_WAIT, HDXH_LK_SHUT} hdxh_lock_t;
endpackage

// [hw/hdxh_top.sv]
`timescale 1ns/10ps
// Summary of operation
// - host access to data buffer clears transfer request
// - wait line asserted whenever transfer request is set
// - controller status write with bit 7 set sets transfer enable
// - with enable set, controller data access sets request and wait
// - host data access makes about 100 ns clear pulse releasing wait
// - transfer enable persists across transfers until cleared
// - controller status write with bit 7 clear clears transfer enable
// - forced init clears enable and request, resets controller
// - host status write also loads data into data buffer
// - host status write with bit 0 or 14 negates done
// - about 100 ns after done negated, block host status writes
// - controller status write with done set lifts lockout, sets done
// - host reset during write gate deferred until write ends
// - host registers decoded at octal 177170 and 177172
// - data buffer is eight bits, read and written by both
// - controller uses four strobes; reads drive 8-bit bus
module hdxh_top
    import hdxh_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // host bus
    input  wire logic [15:0] host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    input  wire logic        host_error,
    input  wire logic        host_init_req,
    // controller bus
    input  wire logic        ctrl_status_read_n,
    input  wire logic        ctrl_status_write_n,
    input  wire logic        ctrl_data_read_n,
    input  wire logic        ctrl_data_write_n,
    input  wire logic [7:0]  ctrl_wdata,
    output logic      [7:0]  ctrl_rdata,
    output logic             ctrl_rdata_oe_n,
    input  wire logic        write_gate,
    // status and control out
    output logic             transfer_request,
    output logic             ctrl_wait_n,
    output logic             ctrl_reset_n,
    output logic             xfer_enable,
    output logic             done
);
    import hdxh_pkg::*;

    logic [7:0]  dbr_ff,    nxt_dbr;
    logic        xen_ff,    nxt_xen;
    logic        treq_ff,   nxt_treq;
    logic        done_ff,   nxt_done;
    logic        intenb_ff, nxt_intenb;
    logic [4:1]  cmd_ff,    nxt_cmd;
    logic [5:0]  pcnt_ff,   nxt_pcnt;
    logic        pact_ff,   nxt_pact;
    logic [5:0]  lcnt_ff,   nxt_lcnt;
    hdxh_lock_t  lk_ff,     nxt_lk;
    logic        rstpend_ff, nxt_rstpend;
    logic        crst_ff,   nxt_crst;
    logic [15:0] hrd_ff,    nxt_hrd;
    logic [7:0]  crd_ff,    nxt_crd;
    logic        coe_ff,    nxt_coe;

    logic host_csr_sel;
    logic host_dbr_sel;
    logic host_csr_wr;
    logic host_dbr_acc;
    logic ctrl_swr;
    logic ctrl_dacc;
    logic clr_pulse;

    always_comb
    begin
        host_csr_sel = (host_addr == HDXH_CSR_ADDR);
        host_dbr_sel = (host_addr == HDXH_DBR_ADDR);
        // lockout shuts only the status write path, data buffer stays open
        host_csr_wr  = host_wr && host_csr_sel && (lk_ff != HDXH_LK_SHUT);
        host_dbr_acc = (host_wr || host_rd) && host_dbr_sel;
        ctrl_swr     = !ctrl_status_write_n;
        ctrl_dacc    = !ctrl_data_read_n || !ctrl_data_write_n;
        clr_pulse    = pact_ff || host_dbr_acc;
    end

    // data buffer, transfer flags, done and lockout
    always_comb
    begin
        nxt_dbr    = dbr_ff;
        nxt_xen    = xen_ff;
        nxt_treq   = treq_ff;
        nxt_done   = done_ff;
        nxt_intenb = intenb_ff;
        nxt_cmd    = cmd_ff;
        nxt_pcnt   = pcnt_ff;
        nxt_pact   = pact_ff;
        nxt_lcnt   = lcnt_ff;
        nxt_lk     = lk_ff;
        // host data buffer access starts the clear pulse
        if (host_dbr_acc)
        begin
            nxt_pact = 1'b1;
            nxt_pcnt = 6'h00;
        end
        else if (pact_ff)
        begin
            if (pcnt_ff == HDXH_PULSE_LAST)
                nxt_pact = 1'b0;
            nxt_pcnt = pcnt_ff + 6'h01;
        end
        if (host_wr && host_dbr_sel)
            nxt_dbr = host_wdata[7:0];
        if (!ctrl_data_write_n)
            nxt_dbr = ctrl_wdata;
        if (host_csr_wr)
        begin
            nxt_dbr    = host_wdata[7:0];
            nxt_intenb = host_wdata[HDXH_BIT_INTENB];
            nxt_cmd    = host_wdata[4:1];
        end
        if (ctrl_swr)
            nxt_xen = ctrl_wdata[HDXH_ZBIT_XEN];
        // pulse holds request clear even if the controller strobes again
        if (clr_pulse)
            nxt_treq = 1'b0;
        else if (xen_ff && ctrl_dacc)
            nxt_treq = 1'b1;
        // lockout sequence
        unique case (lk_ff)
            HDXH_LK_OPEN:
            begin
                if (host_csr_wr && (host_wdata[HDXH_BIT_GO] || host_wdata[HDXH_BIT_INIT]))
                begin
                    nxt_done = 1'b0;
                    nxt_lk   = HDXH_LK_WAIT;
                    nxt_lcnt = 6'h00;
                end
            end
            HDXH_LK_WAIT:
            begin
                nxt_lcnt = lcnt_ff + 6'h01;
                if (lcnt_ff == HDXH_LOCK_LAST)
                    nxt_lk = HDXH_LK_SHUT;
            end
            HDXH_LK_SHUT:
            begin
                nxt_lcnt = lcnt_ff;
            end
        endcase
        if (ctrl_swr && ctrl_wdata[HDXH_ZBIT_DONE])
        begin
            nxt_done = 1'b1;
            nxt_lk   = HDXH_LK_OPEN;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dbr_ff    <= HDXH_DBR_RST;
            done_ff   <= HDXH_DONE_RST;
            intenb_ff <= 1'b0;
            cmd_ff    <= 4'h0;
            pcnt_ff   <= 6'h00;
            pact_ff   <= 1'b0;
            lcnt_ff   <= 6'h00;
            lk_ff     <= HDXH_LK_OPEN;
        end
        else
        begin
            dbr_ff    <= nxt_dbr;
            done_ff   <= nxt_done;
            intenb_ff <= nxt_intenb;
            cmd_ff    <= nxt_cmd;
            pcnt_ff   <= nxt_pcnt;
            pact_ff   <= nxt_pact;
            lcnt_ff   <= nxt_lcnt;
            lk_ff     <= nxt_lk;
        end
    end

    // forced init clears them at the next edge, so the async reset stays constant-only
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            xen_ff  <= 1'b0;
            treq_ff <= 1'b0;
        end
        else if (host_init_req)
        begin
            xen_ff  <= 1'b0;
            treq_ff <= 1'b0;
        end
        else
        begin
            xen_ff  <= nxt_xen;
            treq_ff <= nxt_treq;
        end
    end

    // controller reset, held off while the drive writes
    always_comb
    begin
        nxt_rstpend = rstpend_ff || host_init_req;
        nxt_crst    = 1'b0;
        if (nxt_rstpend && !write_gate)
        begin
            nxt_crst    = 1'b1;
            nxt_rstpend = host_init_req;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstpend_ff <= 1'b0;
            crst_ff    <= 1'b1;
        end
        else
        begin
            rstpend_ff <= nxt_rstpend;
            crst_ff    <= nxt_crst;
        end
    end

    // read data, registered one cycle after the strobe
    always_comb
    begin
        nxt_hrd = 16'h0000;
        nxt_crd = 8'h00;
        nxt_coe = 1'b1;
        if (host_rd && host_csr_sel)
        begin
            nxt_hrd[HDXH_BIT_DONE]   = done_ff;
            nxt_hrd[HDXH_BIT_INTENB] = intenb_ff;
            nxt_hrd[HDXH_BIT_TREQ]   = treq_ff;
            nxt_hrd[HDXH_BIT_ERR]    = host_error;
        end
        else if (host_rd && host_dbr_sel)
            nxt_hrd = {8'h00, dbr_ff};
        if (!ctrl_status_read_n)
        begin
            nxt_crd = {treq_ff, intenb_ff, done_ff, cmd_ff, 1'b0};
            nxt_coe = 1'b0;
        end
        else if (!ctrl_data_read_n)
        begin
            nxt_crd = dbr_ff;
            nxt_coe = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hrd_ff <= 16'h0000;
            crd_ff <= 8'h00;
            coe_ff <= 1'b1;
        end
        else
        begin
            hrd_ff <= nxt_hrd;
            crd_ff <= nxt_crd;
            coe_ff <= nxt_coe;
        end
    end

    always_comb
    begin
        host_rdata       = hrd_ff;
        ctrl_rdata       = crd_ff;
        ctrl_rdata_oe_n  = coe_ff;
        transfer_request = treq_ff;
        ctrl_wait_n      = !treq_ff;
        ctrl_reset_n     = !crst_ff;
        xfer_enable      = xen_ff;
        done             = done_ff;
    end
endmodule

// [tb/hdxh_chk.sv]
`timescale 1ns/10ps
module hdxh_chk
    import hdxh_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // host side
    input wire logic [15:0] host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic        host_init_req,
    // controller side
    input wire logic        ctrl_status_write_n,
    input wire logic        ctrl_data_read_n,
    input wire logic        ctrl_data_write_n,
    input wire logic [7:0]  ctrl_wdata,
    input wire logic        write_gate,
    // flags
    input wire logic        transfer_request,
    input wire logic        ctrl_wait_n,
    input wire logic        ctrl_reset_n,
    input wire logic        xfer_enable,
    input wire logic        done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic       hd;
    logic [5:0] quiet_ff;
    assign hd = (host_wr || host_rd) && host_addr == HDXH_DBR_ADDR;
    // clear pulse still running; one cycle longer to stay safe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            quiet_ff <= 6'h00;
        else
            quiet_ff <= hd ? 6'h1a : quiet_ff - 6'(quiet_ff != 6'h00);
    end
    property p_wait; transfer_request ^ ctrl_wait_n; endproperty
    a_wait: assert property (p_wait) else $error("wait");
    property p_xon; !ctrl_status_write_n && ctrl_wdata[7] && !host_init_req |=> xfer_enable; endproperty
    a_xon: assert property (p_xon) else $error("xen set");
    property p_xoff; !ctrl_status_write_n && !ctrl_wdata[7] |=> !xfer_enable; endproperty
    a_xoff: assert property (p_xoff) else $error("xen clr");
    property p_req; xfer_enable && !(ctrl_data_read_n && ctrl_data_write_n) && !hd && quiet_ff == 6'h00
        && !host_init_req |=> transfer_request; endproperty
    a_req: assert property (p_req) else $error("req set");
    property p_clr; hd |=> !transfer_request [*8]; endproperty
    a_clr: assert property (p_clr) else $error("req clr");
    property p_dneg; done && host_wr && host_addr == HDXH_CSR_ADDR && (host_wdata[0] || host_wdata[14])
        && ctrl_status_write_n |=> !done; endproperty
    a_dneg: assert property (p_dneg) else $error("done neg");
    property p_dset; !ctrl_status_write_n && ctrl_wdata[5] |=> done; endproperty
    a_dset: assert property (p_dset) else $error("done set");
    property p_init; host_init_req && !write_gate |=> !xfer_enable && !transfer_request && !ctrl_reset_n;
    endproperty
    a_init: assert property (p_init) else $error("init");
endmodule
bind hdxh_top hdxh_chk i_hdxh_chk (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .host_addr           (host_addr),
    .host_wr             (host_wr),
    .host_rd             (host_rd),
    .host_wdata          (host_wdata),
    .host_init_req       (host_init_req),
    .ctrl_status_write_n (ctrl_status_write_n),
    .ctrl_data_read_n    (ctrl_data_read_n),
    .ctrl_data_write_n   (ctrl_data_write_n),
    .ctrl_wdata          (ctrl_wdata),
    .write_gate          (write_gate),
    .transfer_request    (transfer_request),
    .ctrl_wait_n         (ctrl_wait_n),
    .ctrl_reset_n        (ctrl_reset_n),
    .xfer_enable         (xfer_enable),
    .done                (done)
);

// [tb/hdxh_ctrl_mdl.sv]
`timescale 1ns/10ps
module hdxh_ctrl_mdl (
    // clock and stall
    input  wire logic       clk_sys,
    input  wire logic       ctrl_wait_n,
    // strobes: data wr, data rd, status wr, status rd
    output logic      [3:0] stb_n,
    output logic      [7:0] wd,
    output logic            hung
);
    initial
    begin
        stb_n = 4'hf;
        wd = 8'h00;
        hung = 1'b0;
    end
    // a stalled processor issues nothing until wait drops or 60 cycles pass, then issues anyway and sets hung
    task automatic acc(input int s, input logic [7:0] d);
        for (int n = 0; !ctrl_wait_n && n < 60; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
        hung = hung | !ctrl_wait_n;
        stb_n[s] = 1'b0;
        wd = d;
        @(posedge clk_sys);
        #1;
        stb_n = 4'hf;
        wd = ~d;
    endtask
endmodule

// [tb/hdxh_tb_top.sv]
`timescale 1ns/10ps
module hdxh_tb_top;
    import hdxh_pkg::*;
    logic        clk_sys, rst_b, host_wr, host_rd, host_error, host_init_req, write_gate;
    logic        ctrl_rdata_oe_n, transfer_request, ctrl_wait_n, ctrl_reset_n, xfer_enable, done, hung;
    logic [15:0] host_addr, host_wdata, host_rdata;
    logic [7:0]  ctrl_rdata, wd, d;
    logic [3:0]  stb_n;
    int          num_errors, total_checks, m_req, m_xen, m_dbr;
    hdxh_top i_hdxh_top (
        .clk_sys             (clk_sys),
        .rst_b               (rst_b),
        .host_addr           (host_addr),
        .host_wr             (host_wr),
        .host_rd             (host_rd),
        .host_wdata          (host_wdata),
        .host_rdata          (host_rdata),
        .host_error          (host_error),
        .host_init_req       (host_init_req),
        .ctrl_status_read_n  (stb_n[3]),
        .ctrl_status_write_n (stb_n[2]),
        .ctrl_data_read_n    (stb_n[1]),
        .ctrl_data_write_n   (stb_n[0]),
        .ctrl_wdata          (wd),
        .ctrl_rdata          (ctrl_rdata),
        .ctrl_rdata_oe_n     (ctrl_rdata_oe_n),
        .write_gate          (write_gate),
        .transfer_request    (transfer_request),
        .ctrl_wait_n         (ctrl_wait_n),
        .ctrl_reset_n        (ctrl_reset_n),
        .xfer_enable         (xfer_enable),
        .done                (done)
    );
    hdxh_ctrl_mdl i_hdxh_ctrl_mdl (.clk_sys(clk_sys), .ctrl_wait_n(ctrl_wait_n), .stb_n(stb_n), .wd(wd), .hung(hung));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic hacc(input logic w, input logic [15:0] a, x);
        host_wr = w;
        host_rd = !w;
        host_addr = a;
        host_wdata = x;
        idle(1);
        host_wr = 1'b0;
        host_rd = 1'b0;
    endtask
    task automatic flags;
        chk(transfer_request, 16'(m_req));
        chk(ctrl_wait_n, 16'(!m_req));
        chk(xfer_enable, 16'(m_xen));
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        {host_wr, host_rd, host_error, host_init_req, write_gate, rst_b} = '0;
        host_addr = 16'h0000;
        host_wdata = 16'h0000;
        {num_errors, total_checks, m_req, m_xen, m_dbr} = '0;
        void'($urandom(32'hafe28842));
        idle(3);
        rst_b = 1'b1;
        idle(1);
        flags;
        chk(done, 16'h0001);
        i_hdxh_ctrl_mdl.acc(2, 8'h80);
        idle(1);
        m_xen = 1;
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($urandom);
            i_hdxh_ctrl_mdl.acc(i % 2, d);
            m_dbr = (i % 2) ? m_dbr : int'(d);
            if (i % 2)
            begin
                chk(ctrl_rdata, 16'(m_dbr));
                chk(ctrl_rdata_oe_n, 16'h0000);
            end
            m_req = 1;
            flags;
            host_error = 1'(i % 2);
            hacc(1'b0, HDXH_CSR_ADDR, 16'h0000);
            chk(host_rdata, {1'(i % 2), 15'h00a0});
            idle(1);
            hacc(1'b0, HDXH_DBR_ADDR, 16'h0000);
            m_req = 0;
            flags;
            chk(host_rdata, 16'(m_dbr));
            chk(ctrl_rdata_oe_n, 16'h0001);
            idle(30);
        end
        fork
            i_hdxh_ctrl_mdl.acc(0, 8'h5a);
            hacc(1'b1, HDXH_DBR_ADDR, 16'h00a5);
        join
        flags;
        idle(30);
        i_hdxh_ctrl_mdl.acc(2, 8'h00);
        m_xen = 0;
        idle(1);
        i_hdxh_ctrl_mdl.acc(0, 8'h11);
        flags;
        d = (8'($urandom) & 8'hbe) | 8'h01;
        hacc(1'b1, HDXH_CSR_ADDR, {8'h40, d});
        chk(done, 16'h0000);
        i_hdxh_ctrl_mdl.acc(1, 8'h00);
        chk(ctrl_rdata, {8'h00, d});
        idle(30);
        hacc(1'b1, HDXH_CSR_ADDR, 16'h0040);
        idle(1);
        hacc(1'b0, HDXH_CSR_ADDR, 16'h0000);
        chk(host_rdata[6], 16'h0000);
        i_hdxh_ctrl_mdl.acc(2, 8'h20);
        chk(done, 16'h0001);
        hacc(1'b1, HDXH_CSR_ADDR, 16'h0040);
        idle(1);
        hacc(1'b0, HDXH_CSR_ADDR, 16'h0000);
        chk(host_rdata[6], 16'h0001);
        i_hdxh_ctrl_mdl.acc(3, 8'h00);
        chk(ctrl_rdata, 16'h0060);
        chk(ctrl_rdata_oe_n, 16'h0000);
        idle(1);
        i_hdxh_ctrl_mdl.acc(2, 8'h80);
        idle(1);
        i_hdxh_ctrl_mdl.acc(0, 8'h33);
        m_xen = 1;
        m_req = 1;
        flags;
        {write_gate, host_init_req} = 2'b11;
        idle(5);
        m_xen = 0;
        m_req = 0;
        chk(ctrl_reset_n, 16'h0001);
        flags;
        write_gate = 1'b0;
        idle(1);
        flags;
        chk(ctrl_reset_n, 16'h0000);
        host_init_req = 1'b0;
        chk(hung, 16'h0000);
        tally_and_finish;
    end
endmodule
